// File: jtag_tap_pkg.sv
/*
 * constants, state codes and pin carriers for the boundary-scan access port.
 * importers: jtag_tap_boundary_scan, which sizes itself from these, jtag_host_model and the bench.
 */
package jtag_tap_pkg;
    // instruction register
    localparam int IR_LEN = 10;
    localparam logic [9:0] IR_CAPTURE_VALUE = 10'h001;
    localparam logic [9:0] OP_BYPASS = 10'h3FF;
    // default opcodes of the other instructions, arbitrary values
    localparam logic [9:0] DEF_OP_SAMPLE = 10'h005;
    localparam logic [9:0] DEF_OP_EXTEST = 10'h000;
    localparam logic [9:0] DEF_OP_IDCODE = 10'h006;
    localparam logic [9:0] DEF_OP_USERSIG = 10'h007;
    localparam logic [9:0] DEF_OP_CLAMP = 10'h00A;
    localparam logic [9:0] DEF_OP_FLOAT = 10'h00B;
    // identification register and its default content, arbitrary value
    localparam int ID_LEN = 32;
    localparam logic [31:0] DEF_ID_VALUE = 32'h0000_0001;
    // boundary cell layout, three bits per pin
    localparam int CELL_BITS = 3;
    localparam int CELL_OUT = 0;
    localparam int CELL_OE = 1;
    localparam int CELL_IN = 2;
    localparam int DEF_PIN_COUNT = 4;
    // consecutive high mode-select edges that force the reset state
    localparam int TLR_TMS_EDGES = 5;

    typedef enum logic [3:0] {
        ST_TLR = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'hA,
        ST_SHIFT_IR = 4'hB,
        ST_EXIT1_IR = 4'hC,
        ST_PAUSE_IR = 4'hD,
        ST_EXIT2_IR = 4'hE,
        ST_UPD_IR = 4'hF
    } tap_state_t;

    typedef enum logic [1:0] {
        DR_BYPASS = 2'h0,
        DR_BOUNDARY = 2'h1,
        DR_IDENT = 2'h2
    } dr_select_t;

    typedef enum logic [1:0] {
        PM_FUNC = 2'h0,
        PM_EXTEST = 2'h1,
        PM_CLAMP = 2'h2,
        PM_FLOAT = 2'h3
    } pin_mode_t;

    // one pin's output side: data and active-low enable
    typedef struct packed {
        logic out;
        logic oe_n;
    } pin_drive_t;
endpackage

// File: jtag_tap_boundary_scan.sv
/*
 * boundary-scan test access port: tap controller, instruction, bypass,
 * identification and boundary registers on tck, pin muxes on mclk.
 * assumes tck, tms, tdi, trst_n come from a test host; core signals and pins
 * belong to the mclk domain; the user signature is quasi-static.
 */
// Behaviour
// - instruction register is ten bits; host shifts exactly ten bits per instruction.
// - sixteen-state controller steps on rising tck by mode-select.
// - reset state disables scan, pins functional, instruction becomes identification.
// - controller starts in reset state after power-up.
// - five high mode-select edges or low test reset force and hold reset state.
// - serial out floats except in shift states; enable changes on falling tck.
// - instruction shifts out on falling tck; stays while mode-select low.
// - instruction bits sampled on rising tck; last bit taken entering exit1.
// - all-ones instruction selects one-bit bypass register.
// - bypass captures on rising edge, drives serial out on following falling edge.
// - capture loads pin input, core enable and core data into cells.
// - sample/preload keeps pins under functional core control.
// - during data shift all cells form one chain in to out.
// - update copies each capture bit into its update register.
// - capture then shift while mode-select low; two highs reach update.
// - extest drives pin data and enable from update registers.
// - enable update bit one floats the pin, zero drives it.
// - extest capture records pin response, shifted out next shift.
// - boundary shift data passes every cell before reaching serial out.
// - clamp drives pins from update data with bypass as serial path.
// - float instruction makes every user pin non-driving.
// - bypass register is exactly one bit.
// - each pin contributes output, enable and input bits to the chain.
// - identification instruction loads and shifts a 32-bit identity value.
// - user signature instruction loads 32-bit signature in parallel then shifts.
`timescale 1ns/10ps
module jtag_tap_boundary_scan
    import jtag_tap_pkg::*;
#(
    parameter int PIN_COUNT = DEF_PIN_COUNT,
    parameter logic [IR_LEN-1:0] OP_SAMPLE = DEF_OP_SAMPLE,
    parameter logic [IR_LEN-1:0] OP_EXTEST = DEF_OP_EXTEST,
    parameter logic [IR_LEN-1:0] OP_IDCODE = DEF_OP_IDCODE,
    parameter logic [IR_LEN-1:0] OP_USERSIG = DEF_OP_USERSIG,
    parameter logic [IR_LEN-1:0] OP_CLAMP = DEF_OP_CLAMP,
    parameter logic [IR_LEN-1:0] OP_FLOAT = DEF_OP_FLOAT,
    parameter logic [ID_LEN-1:0] ID_VALUE = DEF_ID_VALUE
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdoOe_n,
    input wire logic [ID_LEN-1:0] userSignature,
    input wire logic [PIN_COUNT-1:0] coreOutputData,
    input wire logic [PIN_COUNT-1:0] coreOutputEnable_n,
    output logic [PIN_COUNT-1:0] coreInputDrive,
    input wire logic [PIN_COUNT-1:0] pinIn,
    output pin_drive_t [PIN_COUNT-1:0] pinDrive
);
    localparam int BSR_LEN = CELL_BITS * PIN_COUNT;

    // tck domain state, synchronisers included
    typedef struct packed {
        tap_state_t st;
        logic [IR_LEN-1:0] irShift;
        logic [IR_LEN-1:0] ir;
        logic byp;
        logic [ID_LEN-1:0] idShift;
        logic [BSR_LEN-1:0] bsrCap;
        logic [BSR_LEN-1:0] bsrUpd;
        pin_mode_t mode;
        logic updToggle;
        logic inTlr;
        logic [PIN_COUNT-1:0] pinS1;
        logic [PIN_COUNT-1:0] pinS2;
        logic [PIN_COUNT-1:0] oeS1;
        logic [PIN_COUNT-1:0] oeS2;
        logic [PIN_COUNT-1:0] outS1;
        logic [PIN_COUNT-1:0] outS2;
        logic [ID_LEN-1:0] sigS1;
        logic [ID_LEN-1:0] sigS2;
    } tck_state_t;

    // mclk domain state
    typedef struct packed {
        logic togS1;
        logic togS2;
        logic togS3;
        logic rstS1;
        logic rstS2;
        logic [PIN_COUNT-1:0] pinS1;
        logic [PIN_COUNT-1:0] pinS2;
        logic [BSR_LEN-1:0] updCopy;
        pin_mode_t modeCopy;
        logic [PIN_COUNT-1:0] coreIn;
        pin_drive_t [PIN_COUNT-1:0] drive;
    } mclk_state_t;

    localparam tck_state_t TCK_RESET = '{
        st: ST_TLR, ir: OP_IDCODE, mode: PM_FUNC, inTlr: 1'b1, default: '0};
    localparam mclk_state_t MCLK_RESET = '{modeCopy: PM_FUNC, default: '0};

    tck_state_t t_reg, t_next;
    mclk_state_t m_reg, m_next;
    logic tapRst_n;
    logic tdo_reg, tdoOe_n_reg;
    logic tdoNext;
    dr_select_t drSel;
    logic [BSR_LEN-1:0] capVec;

    // controller state graph
    function automatic tap_state_t tapNext(input tap_state_t s, input logic m);
        case (s)
            ST_TLR: tapNext = m ? ST_TLR : ST_IDLE;
            ST_IDLE: tapNext = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: tapNext = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: tapNext = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: tapNext = m ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: tapNext = m ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: tapNext = m ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: tapNext = m ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: tapNext = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: tapNext = m ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: tapNext = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: tapNext = m ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: tapNext = m ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: tapNext = m ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: tapNext = m ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: tapNext = m ? ST_SEL_DR : ST_IDLE;
            default: tapNext = ST_TLR;
        endcase
    endfunction

    // data register chosen by an instruction
    function automatic dr_select_t drOf(input logic [IR_LEN-1:0] op);
        if (op == OP_SAMPLE || op == OP_EXTEST) begin
            drOf = DR_BOUNDARY;
        end else if (op == OP_IDCODE || op == OP_USERSIG) begin
            drOf = DR_IDENT;
        end else begin
            drOf = DR_BYPASS;
        end
    endfunction

    // pin control chosen by an instruction
    function automatic pin_mode_t modeOf(input logic [IR_LEN-1:0] op);
        if (op == OP_EXTEST) begin
            modeOf = PM_EXTEST;
        end else if (op == OP_CLAMP) begin
            modeOf = PM_CLAMP;
        end else if (op == OP_FLOAT) begin
            modeOf = PM_FLOAT;
        end else begin
            modeOf = PM_FUNC;
        end
    endfunction

    // either reset returns the controller to its reset state
    assign tapRst_n = rst_n & trst_n;
    assign drSel = drOf(t_reg.ir);

    // capture word: pin input, core enable, core data per cell
    always_comb begin
        capVec = '0;
        for (int i = 0; i < PIN_COUNT; i++) begin
            capVec[CELL_BITS*i+CELL_OUT] = t_reg.outS2[i];
            capVec[CELL_BITS*i+CELL_OE] = t_reg.oeS2[i];
            capVec[CELL_BITS*i+CELL_IN] = t_reg.pinS2[i];
        end
    end

    // tck domain next state
    always_comb begin
        t_next = t_reg;
        t_next.pinS1 = pinIn;
        t_next.pinS2 = t_reg.pinS1;
        t_next.oeS1 = coreOutputEnable_n;
        t_next.oeS2 = t_reg.oeS1;
        t_next.outS1 = coreOutputData;
        t_next.outS2 = t_reg.outS1;
        t_next.sigS1 = userSignature;
        t_next.sigS2 = t_reg.sigS1;
        t_next.st = tapNext(t_reg.st, tms);
        case (t_reg.st)
            ST_CAP_IR: begin
                t_next.irShift = IR_CAPTURE_VALUE;
            end
            ST_SHIFT_IR: begin
                t_next.irShift = {tdi, t_reg.irShift[IR_LEN-1:1]};
            end
            ST_UPD_IR: begin
                t_next.ir = t_reg.irShift;
                t_next.mode = modeOf(t_reg.irShift);
                t_next.updToggle = ~t_reg.updToggle;
            end
            ST_CAP_DR: begin
                case (drSel)
                    DR_BOUNDARY: t_next.bsrCap = capVec;
                    DR_IDENT: t_next.idShift =
                        (t_reg.ir == OP_USERSIG) ? t_reg.sigS2 : ID_VALUE;
                    default: t_next.byp = 1'b0;
                endcase
            end
            ST_SHIFT_DR: begin
                case (drSel)
                    DR_BOUNDARY: t_next.bsrCap =
                        {tdi, t_reg.bsrCap[BSR_LEN-1:1]};
                    DR_IDENT: t_next.idShift = {tdi, t_reg.idShift[ID_LEN-1:1]};
                    default: t_next.byp = tdi;
                endcase
            end
            ST_UPD_DR: begin
                if (drSel == DR_BOUNDARY) begin
                    t_next.bsrUpd = t_reg.bsrCap;
                end
                t_next.updToggle = ~t_reg.updToggle;
            end
            default: begin
            end
        endcase
        // reset state: scan off, identification selected
        if (t_next.st == ST_TLR) begin
            t_next.ir = OP_IDCODE;
            t_next.mode = PM_FUNC;
        end
        t_next.inTlr = (t_next.st == ST_TLR);
    end

    // tck domain registers
    always_ff @(posedge tck or negedge tapRst_n) begin
        if (!tapRst_n) begin
            t_reg <= TCK_RESET;
        end else begin
            t_reg <= t_next;
        end
    end

    // bit leaving the selected register
    always_comb begin
        case (drSel)
            DR_BOUNDARY: tdoNext = t_reg.bsrCap[0];
            DR_IDENT: tdoNext = t_reg.idShift[0];
            default: tdoNext = t_reg.byp;
        endcase
        if (t_reg.st == ST_SHIFT_IR) begin
            tdoNext = t_reg.irShift[0];
        end
    end

    // serial out changes only on falling tck
    always_ff @(negedge tck or negedge tapRst_n) begin
        if (!tapRst_n) begin
            tdo_reg <= 1'b0;
            tdoOe_n_reg <= 1'b1;
        end else begin
            tdo_reg <= tdoNext;
            tdoOe_n_reg <= !(t_reg.st == ST_SHIFT_IR || t_reg.st == ST_SHIFT_DR);
        end
    end

    assign tdo = tdo_reg;
    assign tdoOe_n = tdoOe_n_reg;

    // mclk side: toggle crossing, then copy of stable update data
    always_comb begin
        m_next = m_reg;
        m_next.togS1 = t_reg.updToggle;
        m_next.togS2 = m_reg.togS1;
        m_next.togS3 = m_reg.togS2;
        m_next.rstS1 = t_reg.inTlr;
        m_next.rstS2 = m_reg.rstS1;
        m_next.pinS1 = pinIn;
        m_next.pinS2 = m_reg.pinS1;
        if (m_reg.togS2 != m_reg.togS3) begin
            m_next.updCopy = t_reg.bsrUpd;
            m_next.modeCopy = t_reg.mode;
        end
        if (m_reg.rstS2) begin
            m_next.modeCopy = PM_FUNC;
        end
        for (int i = 0; i < PIN_COUNT; i++) begin
            m_next.coreIn[i] = m_reg.pinS2[i];
            m_next.drive[i].out = coreOutputData[i];
            m_next.drive[i].oe_n = coreOutputEnable_n[i];
            case (m_reg.modeCopy)
                PM_EXTEST: begin
                    m_next.drive[i].out = m_reg.updCopy[CELL_BITS*i+CELL_OUT];
                    m_next.drive[i].oe_n = m_reg.updCopy[CELL_BITS*i+CELL_OE];
                    m_next.coreIn[i] = m_reg.updCopy[CELL_BITS*i+CELL_IN];
                end
                PM_CLAMP: begin
                    m_next.drive[i].out = m_reg.updCopy[CELL_BITS*i+CELL_OUT];
                    m_next.drive[i].oe_n = m_reg.updCopy[CELL_BITS*i+CELL_OE];
                end
                PM_FLOAT: begin
                    m_next.drive[i].oe_n = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // mclk domain registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            m_reg <= MCLK_RESET;
        end else begin
            m_reg <= m_next;
        end
    end

    assign coreInputDrive = m_reg.coreIn;
    assign pinDrive = m_reg.drive;

    // five high mode-select edges land in reset state
    a_five_high_reset: assert property (@(posedge tck) disable iff (!tapRst_n)
        tms [*5] |=> t_reg.st == ST_TLR) else $error("tms high x5 missed reset");
    // mode-select high keeps the reset state
    a_reset_hold: assert property (@(posedge tck) disable iff (!tapRst_n)
        t_reg.st == ST_TLR && tms |=> t_reg.st == ST_TLR) else $error("reset state left");
    // reset state holds the identification instruction
    a_reset_ident: assert property (@(posedge tck) disable iff (!tapRst_n)
        t_reg.st == ST_TLR |-> t_reg.ir == OP_IDCODE && t_reg.mode == PM_FUNC)
        else $error("reset state without identification");
    // serial out enabled inside a shift state, floating in idle
    a_tdo_enable: assert property (@(posedge tck) disable iff (!tapRst_n)
        (t_reg.st == ST_SHIFT_DR || t_reg.st == ST_SHIFT_IR) [*2] |-> !tdoOe_n)
        else $error("tdo not driven in shift");
    a_tdo_float: assert property (@(posedge tck) disable iff (!tapRst_n)
        (t_reg.st == ST_IDLE) [*2] |-> tdoOe_n) else $error("tdo driven outside shift");
    // instruction shift takes serial in at the top
    a_ir_shift: assert property (@(posedge tck) disable iff (!tapRst_n)
        t_reg.st == ST_SHIFT_IR |=> t_reg.irShift ==
        {$past(tdi), $past(t_reg.irShift[IR_LEN-1:1])}) else $error("ir shift wrong");
    // boundary shift moves the chain one bit towards serial out
    a_chain_shift: assert property (@(posedge tck) disable iff (!tapRst_n)
        t_reg.st == ST_SHIFT_DR && drSel == DR_BOUNDARY |=> t_reg.bsrCap ==
        {$past(tdi), $past(t_reg.bsrCap[BSR_LEN-1:1])}) else $error("chain shift wrong");
    // bypass carries one bit per clock
    a_bypass_bit: assert property (@(posedge tck) disable iff (!tapRst_n)
        t_reg.st == ST_SHIFT_DR && drSel == DR_BYPASS ##1 t_reg.st == ST_SHIFT_DR
        |-> t_reg.byp == $past(tdi) && tdo == t_reg.byp) else $error("bypass path wrong");
    // update copies the captured chain
    a_update_copy: assert property (@(posedge tck) disable iff (!tapRst_n)
        t_reg.st == ST_UPD_DR && drSel == DR_BOUNDARY |=> t_reg.bsrUpd == $past(t_reg.bsrCap))
        else $error("update did not copy chain");
    // capture loads pins and core signals
    a_capture_pins: assert property (@(posedge tck) disable iff (!tapRst_n)
        t_reg.st == ST_CAP_DR && drSel == DR_BOUNDARY |=> t_reg.bsrCap == $past(capVec))
        else $error("capture missed pin data");
    // identity word loaded on capture
    a_ident_load: assert property (@(posedge tck) disable iff (!tapRst_n)
        t_reg.st == ST_CAP_DR && t_reg.ir == OP_IDCODE |=> t_reg.idShift == ID_VALUE)
        else $error("identity not loaded");
    // float mode leaves the first and last pins undriven
    a_float_pins: assert property (@(posedge mclk) disable iff (!rst_n)
        m_reg.modeCopy == PM_FLOAT |=> &{m_reg.drive[0].oe_n, m_reg.drive[PIN_COUNT-1].oe_n})
        else $error("pin driven in float mode");
    // extest forces update data onto the first pin
    a_extest_drive: assert property (@(posedge mclk) disable iff (!rst_n)
        m_reg.modeCopy == PM_EXTEST && !m_reg.rstS2 ##1 m_reg.modeCopy == PM_EXTEST
        |-> m_reg.drive[0].out == $past(m_reg.updCopy[CELL_OUT]))
        else $error("extest data not on pin");
    // clamp forces update data and enable onto the first pin
    a_clamp_drive: assert property (@(posedge mclk) disable iff (!rst_n)
        m_reg.modeCopy == PM_CLAMP ##1 m_reg.modeCopy == PM_CLAMP
        |-> m_reg.drive[0].out == $past(m_reg.updCopy[CELL_OUT])
        && m_reg.drive[0].oe_n == $past(m_reg.updCopy[CELL_OE]))
        else $error("clamp data not on pin");
endmodule

// File: jtag_host_model.sv
/*
 * test host model: drives tck only within frames, plus tms, tdi and trst_n,
 * and reads tdo back once each falling tck edge has settled.
 * assumes the bench calls its tasks one at a time and judges the results.
 */
`timescale 1ns/10ps
module jtag_host_model
    import jtag_tap_pkg::*;
(
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo,
    input wire logic tdoOe_n
);
    // idle levels: clock parked low, mode-select high
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end

    // one 48 ns tck period, inputs set while tck is low
    task automatic pulse(input logic m, input logic d);
        tms = m;
        tdi = d;
        #12 tck = 1'b1;
        #24 tck = 1'b0;
        #12;
    endtask

    // shift n bits lsb first from a shift state, then go on to update and idle
    task automatic scan(input int n, input logic [63:0] din, output logic [63:0] dout,
        output logic bad);
        dout = '0;
        bad = 1'b0;
        for (int i = 0; i < n; i++) begin
            dout[i] = tdoOe_n ? ~tdo : tdo; // a released line reads inverted
            bad |= (tdoOe_n !== 1'b0);
            pulse(i == n - 1, din[i]);
        end
        bad |= (tdoOe_n !== 1'b1);
        pulse(1'b1, ~tdi);
        pulse(1'b0, ~tdi);
    endtask

    // from idle into instruction shift, ten bits in, back to idle
    task automatic loadIr(input logic [9:0] op, output logic [9:0] cap, output logic bad);
        logic [63:0] o;
        pulse(1'b1, ~tdi);
        pulse(1'b1, ~tdi);
        pulse(1'b0, ~tdi);
        pulse(1'b0, ~tdi);
        scan(IR_LEN, 64'(op), o, bad);
        cap = o[9:0];
    endtask

    // from idle through capture into data shift
    task automatic scanDr(input int n, input logic [63:0] din, output logic [63:0] dout,
        output logic bad);
        pulse(1'b1, ~tdi);
        pulse(1'b0, ~tdi);
        pulse(1'b0, ~tdi);
        scan(n, din, dout, bad);
    endtask

    // test reset held low with the clock stopped
    task automatic pullTrst();
        trst_n = 1'b0;
        #100 trst_n = 1'b1;
        #12;
    endtask
endmodule

// File: jtag_tap_boundary_scan_tb.sv
/*
 * self-checking bench for the boundary-scan access port.
 * assumes the host model drives the tck side; core inputs change on falling mclk.
 */
`timescale 1ns/10ps
module jtag_tap_boundary_scan_tb;
    import jtag_tap_pkg::*;
    localparam int P = DEF_PIN_COUNT;
    localparam int BL = CELL_BITS * P;
    logic mclk;
    logic rst_n;
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
    logic tdo;
    logic tdoOe_n;
    logic [ID_LEN-1:0] userSignature;
    logic [P-1:0] coreOutputData;
    logic [P-1:0] coreOutputEnable_n;
    logic [P-1:0] coreInputDrive;
    logic [P-1:0] pinIn;
    logic [P-1:0] extIn;
    pin_drive_t [P-1:0] pinDrive;
    int numErrors = 0;
    int nCompared = 0;
    int seed = 32'h8bee_de4a;
    logic [63:0] din;
    logic [63:0] dout;
    logic [63:0] pre;
    logic [9:0] cap;
    logic [9:0] op;
    logic bad;

    jtag_tap_boundary_scan #(.PIN_COUNT(P)) dut (.mclk(mclk), .rst_n(rst_n), .tck(tck),
        .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdoOe_n(tdoOe_n),
        .userSignature(userSignature), .coreOutputData(coreOutputData),
        .coreOutputEnable_n(coreOutputEnable_n), .coreInputDrive(coreInputDrive),
        .pinIn(pinIn), .pinDrive(pinDrive));
    jtag_host_model host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
        .tdoOe_n(tdoOe_n));

    // pin wire: the driven level, or the outside world when floating
    always_comb begin
        for (int i = 0; i < P; i++) begin
            pinIn[i] = pinDrive[i].oe_n ? extIn[i] : pinDrive[i].out;
        end
    end

    // expected pin level from data, active-low enable and outside value
    function automatic logic [P-1:0] wire_of(input logic [P-1:0] d, input logic [P-1:0] e,
        input logic [P-1:0] x);
        wire_of = (e & x) | (~e & d);
    endfunction

    // one field of every cell taken from a chain image
    function automatic logic [P-1:0] cells(input logic [63:0] v, input int k);
        for (int i = 0; i < P; i++) begin
            cells[i] = v[CELL_BITS * i + k];
        end
    endfunction

    // captured chain image: per cell data, enable, pin
    function automatic logic [63:0] capExp(input logic [P-1:0] d, input logic [P-1:0] e,
        input logic [P-1:0] p);
        capExp = '0;
        for (int i = 0; i < P; i++) begin
            capExp[CELL_BITS * i + CELL_OUT] = d[i];
            capExp[CELL_BITS * i + CELL_OE] = e[i];
            capExp[CELL_BITS * i + CELL_IN] = p[i];
        end
    endfunction

    // pin drive image as packed: out above oe_n per pin
    function automatic logic [63:0] drvExp(input logic [P-1:0] d, input logic [P-1:0] e);
        drvExp = '0;
        for (int i = 0; i < P; i++) begin
            drvExp[2 * i + 1] = d[i];
            drvExp[2 * i] = e[i];
        end
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        nCompared++;
        if (seen !== exp) begin
            numErrors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic closeOut();
        if (numErrors == 0 && nCompared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // new random core values on the falling edge, then let pins settle
    task automatic randCore();
        @(negedge mclk);
        coreOutputData = P'($random(seed));
        coreOutputEnable_n = P'($random(seed));
        extIn = P'($random(seed));
        repeat (10) @(negedge mclk);
    endtask

    // functional pins and id readout, as after any entry to reset
    task automatic checkReset();
        repeat (10) @(negedge mclk);
        check(64'(pinDrive), drvExp(coreOutputData, coreOutputEnable_n));
        check(64'(coreInputDrive), 64'(pinIn));
        host.scanDr(ID_LEN, 64'($random(seed)), dout, bad);
        check(dout, 64'(DEF_ID_VALUE));
        check(64'(bad), 64'h0);
    endtask

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // watchdog well beyond the expected run length
    initial begin
        #600000;
        numErrors++;
        closeOut();
    end

    initial begin
        rst_n = 1'b0;
        userSignature = $random(seed);
        coreOutputData = '0;
        coreOutputEnable_n = '0;
        extIn = '0;
        host.pulse(1'b1, 1'b0);
        host.pulse(1'b1, 1'b1);
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        check(64'(tdoOe_n), 64'h1);
        randCore();
        host.pulse(1'b0, 1'b0);
        checkReset();
        // sample/preload: snapshot, full chain pass, pins stay functional
        randCore();
        host.loadIr(DEF_OP_SAMPLE, cap, bad);
        check(64'(cap), 64'(IR_CAPTURE_VALUE));
        din = {$random(seed), $random(seed)};
        host.scanDr(2 * BL, din, dout, bad);
        check(dout[BL-1:0], capExp(coreOutputData, coreOutputEnable_n,
            wire_of(coreOutputData, coreOutputEnable_n, extIn)));
        check(dout[2*BL-1:BL], din[BL-1:0]);
        pre = din >> BL;
        repeat (10) @(negedge mclk);
        check(64'(pinDrive), drvExp(coreOutputData, coreOutputEnable_n));
        check(64'(bad), 64'h0);
        host.loadIr(DEF_OP_USERSIG, cap, bad);
        host.scanDr(ID_LEN, 64'($random(seed)), dout, bad);
        check(dout, 64'(userSignature));
        // bypass path for all-ones, an unassigned code, clamp and float
        for (int k = 0; k < 4; k++) begin
            op = (k == 0) ? OP_BYPASS : (k == 1) ? 10'h155 :
                (k == 2) ? DEF_OP_CLAMP : DEF_OP_FLOAT;
            randCore();
            host.loadIr(op, cap, bad);
            din = {$random(seed), $random(seed)};
            host.scanDr(16, din, dout, bad);
            check(dout[15:0], {din[14:0], 1'b0});
            repeat (10) @(negedge mclk);
            if (k == 2) begin
                check(64'(pinDrive),
                    drvExp(cells(pre, CELL_OUT), cells(pre, CELL_OE)));
            end else if (k == 3) begin
                check(64'(pinDrive) & 64'h55, 64'h55);
            end else begin
                check(64'(pinDrive), drvExp(coreOutputData, coreOutputEnable_n));
            end
        end
        // extest: preloaded values forced, pin response captured, new update
        randCore();
        host.loadIr(DEF_OP_EXTEST, cap, bad);
        repeat (10) @(negedge mclk);
        check(64'(pinDrive), drvExp(cells(pre, CELL_OUT), cells(pre, CELL_OE)));
        check(64'(coreInputDrive), 64'(cells(pre, CELL_IN)));
        din = 64'($random(seed));
        host.scanDr(BL, din, dout, bad);
        check(dout[BL-1:0], capExp(coreOutputData, coreOutputEnable_n,
            wire_of(cells(pre, CELL_OUT), cells(pre, CELL_OE), extIn)));
        repeat (10) @(negedge mclk);
        check(64'(pinDrive), drvExp(cells(din, CELL_OUT), cells(din, CELL_OE)));
        check(64'(pinIn),
            64'(wire_of(cells(din, CELL_OUT), cells(din, CELL_OE), extIn)));
        // five high mode-select edges return to reset
        repeat (5) host.pulse(1'b1, 1'b0);
        host.pulse(1'b0, 1'b0);
        checkReset();
        // test reset low returns to reset from extest
        host.loadIr(DEF_OP_EXTEST, cap, bad);
        host.pullTrst();
        host.pulse(1'b0, 1'b0);
        checkReset();
        closeOut();
    end
endmodule
